/* serial_port_pkg.sv */
// constants for the serial port control register block
package serial_port_pkg;
  localparam int          ADDR_W          = 21;
  localparam int          DATA_W          = 16;
  localparam logic [20:0] CTRL_ADDR       = 21'h1f0000;
  localparam logic [20:0] AN_STATUS_ADDR  = 21'h1f8002;
  // control register field positions
  localparam int          BIT_SOFT_RESET  = 15;
  localparam int          BIT_LOOPBACK    = 14;
  localparam int          BIT_SPEED_LSB   = 13;
  localparam int          BIT_AN_ENABLE   = 12;
  localparam int          BIT_POWER_DOWN  = 11;
  localparam int          BIT_AN_RESTART  = 9;
  localparam int          BIT_FULL_DUPLEX = 8;
  localparam int          BIT_SPEED_MSB   = 6;
  // writable bits; reserved bits read zero
  localparam logic [15:0] CTRL_WMASK      = 16'hfb40;
  localparam logic [15:0] CTRL_RESET      = 16'h1140;
  // status register field positions
  localparam int          ST_SPEED_LO     = 0;
  localparam int          ST_DUPLEX       = 2;
  localparam int          ST_AN_DONE      = 4;
  localparam logic [1:0]  SPEED_10        = 2'h0;
  localparam logic [1:0]  SPEED_100       = 2'h1;
  localparam logic [1:0]  SPEED_1000      = 2'h2;
  localparam logic [1:0]  SPEED_RSVD      = 2'h3;
endpackage : serial_port_pkg

/* pin_sync.sv */
// three-stage synchroniser for one input from outside the clock domain
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // raw and filtered level
  input  wire logic raw_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // first stage is read only by the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_out <= s3_reg;
    end
  end
endmodule : pin_sync

/* sgmii_port_control.sv */
// control register and status reporting for the serial port of the switch
`timescale 1ns/1ps
module sgmii_port_control
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // indirect portal from the port register logic
  input  wire logic [ADDR_W-1:0] portal_addr,
  input  wire logic [DATA_W-1:0] portal_wdata,
  input  wire logic              portal_wr,
  input  wire logic              portal_rd,
  output logic      [DATA_W-1:0] portal_rdata,
  output logic                   portal_rvalid,
  // results from the PCS negotiation engine
  input  wire logic              an_ack_exchanged,
  input  wire logic [1:0]        an_speed_detected,
  input  wire logic              an_duplex_detected,
  input  wire logic              an_restart_taken,
  // serial side link indication from the analog front end
  input  wire logic              rx_link_pin,
  // controls to PCS and SerDes, and the synchronised link level
  output logic                   block_reset,
  output logic                   pcs_loopback,
  output logic [1:0]             link_speed,
  output logic                   an_enable,
  output logic                   an_restart,
  output logic                   full_duplex,
  output logic                   rx_enable,
  output logic                   tx_enable,
  output logic                   clk_gate_en,
  output logic                   rx_link_up
);
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] ctrl_next;
  logic              done_reg;
  logic [1:0]        st_speed_reg;
  logic              st_duplex_reg;
  logic              soft_rst_reg;
  logic              ctrl_hit;
  logic              stat_hit;
  logic              an_clear;
  logic              an_capture;
  logic [DATA_W-1:0] status_word;

  assign ctrl_hit = (portal_addr == CTRL_ADDR);
  assign stat_hit = (portal_addr == AN_STATUS_ADDR);

  // next control value: writes mask reserved bits, restart drops once taken
  always_comb begin
    ctrl_next = ctrl_reg;
    if (an_restart_taken) begin
      ctrl_next[BIT_AN_RESTART] = 1'b0;
    end
    if (portal_wr && ctrl_hit) begin
      ctrl_next = portal_wdata & CTRL_WMASK;
      // a fresh restart request wins over the clear in the same cycle
      if (!portal_wdata[BIT_AN_RESTART] && an_restart_taken) begin
        ctrl_next[BIT_AN_RESTART] = 1'b0;
      end
    end
  end

  // control register; soft reset returns it to defaults one cycle later
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (soft_rst_reg) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // soft reset pulse: the stored bit lasts two cycles, so the pulse blocks itself on the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= ctrl_reg[BIT_SOFT_RESET] && !soft_rst_reg;
    end
  end

  // results go stale on soft reset, power-down or a pending restart
  assign an_clear   = soft_rst_reg || ctrl_reg[BIT_POWER_DOWN] || ctrl_reg[BIT_AN_RESTART];
  // a disabled negotiation never captures, so the status keeps its last value, zero after reset
  assign an_capture = an_ack_exchanged && ctrl_reg[BIT_AN_ENABLE];

  // completion flag; the clear wins, since a restart makes any result stale
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (an_clear) begin
      done_reg <= 1'b0;
    end else if (an_capture) begin
      done_reg <= 1'b1;
    end
  end

  // detected speed and duplex, taken together with the completion flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_speed_reg  <= SPEED_10;
      st_duplex_reg <= 1'b0;
    end else if (an_clear) begin
      st_speed_reg  <= SPEED_10;
      st_duplex_reg <= 1'b0;
    end else if (an_capture) begin
      st_speed_reg  <= an_speed_detected;
      st_duplex_reg <= an_duplex_detected;
    end
  end

  // status word; unused bits read zero
  always_comb begin
    status_word                   = '0;
    status_word[ST_SPEED_LO +: 2] = st_speed_reg;
    status_word[ST_DUPLEX]        = st_duplex_reg;
    status_word[ST_AN_DONE]       = done_reg;
  end

  // read answer strobe, exactly one cycle after each request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portal_rvalid <= 1'b0;
    end else begin
      portal_rvalid <= portal_rd;
    end
  end

  // registered read data, held until the next read; unmapped addresses read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portal_rdata <= '0;
    end else if (portal_rd) begin
      if (ctrl_hit) begin
        portal_rdata <= ctrl_reg & CTRL_WMASK;
      end else if (stat_hit) begin
        portal_rdata <= status_word;
      end else begin
        portal_rdata <= '0;
      end
    end
  end

  // reset pulse toward the PCS and the analog front end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      block_reset <= 1'b0;
    end else begin
      block_reset <= soft_rst_reg;
    end
  end

  // local loopback inside the PCS
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pcs_loopback <= CTRL_RESET[BIT_LOOPBACK];
    end else begin
      pcs_loopback <= ctrl_reg[BIT_LOOPBACK];
    end
  end

  // speed code; the reserved code passes unchanged, so the PCS must treat it as invalid
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      link_speed <= {CTRL_RESET[BIT_SPEED_MSB], CTRL_RESET[BIT_SPEED_LSB]};
    end else begin
      link_speed <= {ctrl_reg[BIT_SPEED_MSB], ctrl_reg[BIT_SPEED_LSB]};
    end
  end

  // negotiation enable and the restart request held until the engine takes it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      an_enable  <= CTRL_RESET[BIT_AN_ENABLE];
      an_restart <= CTRL_RESET[BIT_AN_RESTART];
    end else begin
      an_enable  <= ctrl_reg[BIT_AN_ENABLE];
      an_restart <= ctrl_reg[BIT_AN_RESTART];
    end
  end

  // forced duplex
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      full_duplex <= CTRL_RESET[BIT_FULL_DUPLEX];
    end else begin
      full_duplex <= ctrl_reg[BIT_FULL_DUPLEX];
    end
  end

  // power-down stops receiver, transmitter and clocks together
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_enable   <= !CTRL_RESET[BIT_POWER_DOWN];
      tx_enable   <= !CTRL_RESET[BIT_POWER_DOWN];
      clk_gate_en <= !CTRL_RESET[BIT_POWER_DOWN];
    end else begin
      rx_enable   <= !ctrl_reg[BIT_POWER_DOWN];
      tx_enable   <= !ctrl_reg[BIT_POWER_DOWN];
      clk_gate_en <= !ctrl_reg[BIT_POWER_DOWN];
    end
  end

  // link pin comes from the analog side, so it is synchronised
  pin_sync link_sync (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .raw_in    (rx_link_pin),
    .level_out (rx_link_up)
  );
endmodule : sgmii_port_control

/* sgmii_port_control_properties.sv */
// checker for the serial port control block ports
`timescale 1ns/1ps
module sgmii_port_control_properties
  import serial_port_pkg::*;
(
  // watched ports
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [20:0] portal_addr,
  input wire logic [15:0] portal_wdata,
  input wire logic        portal_wr,
  input wire logic        portal_rd,
  input wire logic        portal_rvalid,
  input wire logic        block_reset,
  input wire logic        pcs_loopback,
  input wire logic [1:0]  link_speed,
  input wire logic        an_enable,
  input wire logic        rx_enable,
  input wire logic        tx_enable,
  input wire logic        clk_gate_en,
  input wire logic        full_duplex
);
  logic        cw;
  logic        sw;
  logic [15:0] w1, w2;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // plain control write; outputs lag it by two edges
  assign cw = portal_wr && portal_addr == CTRL_ADDR && !portal_wdata[15] && !block_reset;
  // soft reset request written to the control register
  assign sw = portal_wr && portal_addr == CTRL_ADDR && portal_wdata[15] && !block_reset;
  // write data two edges old, kept here since $past may not sit in an assign
  always_ff @(posedge sys_clk) begin
    w1 <= portal_wdata;
    w2 <= w1;
  end
  a_rd_answer: assert property (portal_rd |=> portal_rvalid)
    else $error("read not answered");
  a_rd_cause: assert property (portal_rvalid |-> $past(portal_rd))
    else $error("answer without read");
  a_rst_pulse: assert property (block_reset |=> !block_reset)
    else $error("reset pulse too long");
  a_soft_rst: assert property (sw |-> ##[2:4] block_reset)
    else $error("soft reset missing");
  a_soft_defaults: assert property (block_reset |=> an_enable && full_duplex
    && !pcs_loopback && link_speed == SPEED_1000 && rx_enable && tx_enable && clk_gate_en)
    else $error("defaults not restored after soft reset");
  a_loop_follow: assert property (cw |-> ##2 pcs_loopback == w2[14])
    else $error("loopback wrong");
  a_speed_follow: assert property (cw |-> ##2 link_speed == {w2[6], w2[13]})
    else $error("speed wrong");
  a_an_follow: assert property (cw |-> ##2 an_enable == w2[12])
    else $error("negotiation enable wrong");
  a_pd_follow: assert property (cw |-> ##2 rx_enable == !w2[11])
    else $error("power-down wrong");
  a_tx_follow: assert property (cw |-> ##2 tx_enable == !w2[11])
    else $error("transmitter power-down wrong");
  a_clk_follow: assert property (cw |-> ##2 clk_gate_en == !w2[11])
    else $error("clock power-down wrong");
  a_duplex_follow: assert property (cw |-> ##2 full_duplex == w2[8])
    else $error("duplex wrong");
endmodule : sgmii_port_control_properties
bind sgmii_port_control sgmii_port_control_properties u_props (.*);

/* sgmii_link_partner.sv */
// negotiation engine model on the far side of the control block
`timescale 1ns/1ps
module sgmii_link_partner (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // restart in, negotiated result out
  input  wire logic       an_restart,
  input  wire logic [1:0] offer_speed,
  output logic            an_restart_taken,
  output logic            an_ack_exchanged,
  output logic [1:0]      an_speed_detected,
  output logic            an_duplex_detected
);
  int cnt;
  // slow answer: restart taken after 3 cycles, acknowledge after 9
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cnt <= 0;
    else if (an_restart && (cnt == 0 || cnt == 9)) cnt <= 1;
    else if (cnt != 0 && cnt < 9) cnt <= cnt + 1;
  end
  assign an_restart_taken = (cnt == 3);
  assign an_ack_exchanged = (cnt == 9);
  // result is garbage until acknowledged, so early capture shows up
  assign an_speed_detected = an_ack_exchanged ? offer_speed : ~offer_speed;
  assign an_duplex_detected = an_speed_detected[0];
endmodule : sgmii_link_partner

/* sgmii_port_control_tb.sv */
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module sgmii_port_control_tb;
  import serial_port_pkg::*;
  logic        sys_clk = 0, rst = 1, portal_wr = 0, portal_rd = 0, rx_link_pin = 1;
  logic [20:0] portal_addr = 0;
  logic [15:0] portal_wdata = 0, portal_rdata, rdv;
  logic [1:0]  offer_speed = 0, an_speed_detected, link_speed;
  logic        portal_rvalid, an_ack_exchanged, an_duplex_detected, an_restart_taken;
  logic        block_reset, pcs_loopback, an_enable, an_restart, full_duplex;
  logic        rx_enable, tx_enable, clk_gate_en, rx_link_up;
  int          err_count = 0, n_compared = 0, ctrl_model, w, i;
  sgmii_port_control u_dut (.*);
  sgmii_link_partner u_peer (.*);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // a bounded wait that ran out ends the run
  task automatic bail(input int k, input int lim);
    if (k == lim) begin
      err_count++;
      finish_test;
    end
  endtask : bail
  // one-cycle strobes launched on the falling edge
  task automatic wr_reg(input logic [20:0] a, input logic [15:0] d);
    @(negedge sys_clk) {portal_wr, portal_addr, portal_wdata} = {1'b1, a, d};
    @(negedge sys_clk) portal_wr = 0;
  endtask : wr_reg
  task automatic rd_reg(input logic [20:0] a);
    @(negedge sys_clk) {portal_rd, portal_addr} = {1'b1, a};
    @(negedge sys_clk) portal_rd = 0;
    check({15'h0, portal_rvalid}, 16'h1);
    rdv = portal_rdata;
  endtask : rd_reg
  // controls must mirror the modelled register
  task automatic out_chk;
    check({8'h0, pcs_loopback, link_speed, an_enable, full_duplex, rx_enable, tx_enable,
      clk_gate_en}, {8'h0, ctrl_model[14], ctrl_model[6], ctrl_model[13], ctrl_model[12],
      ctrl_model[8], {3{~ctrl_model[11]}}});
  endtask : out_chk
  initial begin
    void'($urandom(32'he4a11b03));
    repeat (20) @(negedge sys_clk);
    rst = 0;
    ctrl_model = CTRL_RESET;
    rd_reg(CTRL_ADDR);
    check(rdv, 16'h1140);
    out_chk;
    // the link level needs the synchroniser stages to fill after reset
    repeat (2) @(negedge sys_clk);
    check({15'h0, rx_link_up}, 16'h1);
    $display("end reset");
    // every speed code, random other bits with soft reset and restart held clear, reserved bits must drop
    for (i = 0; i < 8; i++) begin
      w = $urandom & 32'h7dff;
      w[6] = i[1];
      w[13] = i[0];
      wr_reg(CTRL_ADDR, w[15:0]);
      ctrl_model = w & 32'h7940;
      rd_reg(CTRL_ADDR);
      check(rdv, ctrl_model[15:0]);
      out_chk;
    end
    wr_reg(21'h1f0001, 16'hffff);
    rd_reg(21'h1f0001);
    check(rdv, 16'h0);
    rd_reg(CTRL_ADDR);
    check(rdv, ctrl_model[15:0]);
    // a dropped link pin shows after the synchroniser, and so does its return
    rx_link_pin = 0;
    repeat (4) @(negedge sys_clk);
    check({15'h0, rx_link_up}, 16'h0);
    rx_link_pin = 1;
    repeat (4) @(negedge sys_clk);
    check({15'h0, rx_link_up}, 16'h1);
    $display("end writes");
    // leave power-down, restart, then copy the result back by hand
    offer_speed = 2'($urandom);
    wr_reg(CTRL_ADDR, 16'h1340);
    @(negedge sys_clk);
    check({15'h0, an_restart}, 16'h1);
    for (i = 0; i < 40 && rdv[4] !== 1'b1; i++) rd_reg(AN_STATUS_ADDR);
    bail(i, 40);
    check(rdv, {11'h0, 1'b1, 1'b0, offer_speed[0], offer_speed});
    rd_reg(CTRL_ADDR);
    check(rdv, 16'h1140);
    check({15'h0, an_restart}, 16'h0);
    ctrl_model = {2'h0, offer_speed[0], 4'h8, offer_speed[0], 1'b0, offer_speed[1], 6'h0};
    wr_reg(CTRL_ADDR, ctrl_model[15:0]);
    repeat (2) @(negedge sys_clk);
    out_chk;
    $display("end restart");
    // soft reset returns the defaults
    wr_reg(CTRL_ADDR, 16'hc800);
    for (i = 0; i < 8 && block_reset !== 1'b1; i++) @(negedge sys_clk);
    bail(i, 8);
    ctrl_model = CTRL_RESET;
    rd_reg(CTRL_ADDR);
    check(rdv, 16'h1140);
    out_chk;
    $display("end soft reset");
    finish_test;
  end
endmodule : sgmii_port_control_tb
